// [common/nvm_pkg.sv]
// Notes on behaviour
// - Serial output changes only after a falling clock edge, one bit each.
// - Opcode, address and data bits are taken on rising clock edges.
// - Chip select high means output off; standby unless a write runs.
// - After power-up nothing runs until chip select has fallen once.
// - Guard input low blocks every nonvolatile write; reads still work.
// - Guard falling during a frame drops the pending write; a running one carries on to its end.
// - Eight-bit instruction register; all fields travel MSB first.
// - First bit is taken on the first rise; a halted clock resumes in place.
// - Enable latch set and cleared by commands, cleared at reset and program end.
// - Protection holds until rewritten; protected sectors read but never program.
// - Status byte carries protect select in bits 2..0; bits 7..3 are zero.
// - Read is opcode plus 16-bit address; only low 9 bits are used.
// - Read address increments per byte, wraps 0x1FF to 0, ends at deselect.
// - Enable must end its own frame; a program run on after it is ignored.
// - Sector program is opcode, address, 16 bytes: 152 clocks, select low.
// - Write starts only if select rises right after the last data bit.
// - Status read returns the protect bits with zero reserved bits.
// - During a write, status read drives ones; then the live status bit.
// - Status bit pointer advances every clock, wrapping after eight bits.
// - Latch set is 0x06, latch clear is 0x04.
// - Status read 0x05, program 0x02, read 0x03, status program 0x01.
// - Status program needs the latch; deselect after two bytes writes it.
// - Codes 0..7 protect none, Q1..Q4, lower half, lowest, highest sector.
`default_nettype none
package nvm_pkg;
  // -------------------------------------------------------------------------
  // Instruction codes
  // -------------------------------------------------------------------------
  // enable latch codes
  localparam logic [7:0] write_latch_set_cmd = 8'h06;
  localparam logic [7:0] write_latch_clear_cmd = 8'h04;
  localparam logic [7:0] cmd_status_write = 8'h01;
  localparam logic [7:0] cmd_program = 8'h02;
  localparam logic [7:0] cmd_read = 8'h03;
  localparam logic [7:0] cmd_status_read = 8'h05;

  // -------------------------------------------------------------------------
  // Bit counts within a frame
  // -------------------------------------------------------------------------
  localparam logic [7:0] op_end = 8'h08;
  localparam logic [7:0] stat_end = 8'h10;
  localparam logic [7:0] addr_end = 8'h18;
  localparam logic [7:0] first_byte_end = 8'h20;
  localparam logic [7:0] prog_end = 8'h98;
  localparam int sector_bytes = 16;
  localparam int mem_words = 512;

  // -------------------------------------------------------------------------
  // Reset values and timing
  // -------------------------------------------------------------------------
  localparam logic [2:0] protect_reset = 3'h0;
  localparam int write_time_us = 5000;
  localparam int clk_mhz = 10;
  localparam int write_cycles = write_time_us * clk_mhz;

  // Action left behind by the last frame, read after deselect
  typedef enum logic [2:0] {
    act_none, act_latch_set, act_latch_clr, act_prog, act_stat
  } act_t;

  typedef struct packed {
    logic [4:0] zero;
    logic [2:0] protect_select;
  } status_byte_t;

  function automatic logic protect_hit(input logic [2:0] sel,
                                       input logic [8:0] a);
    case (sel)
      3'h1: protect_hit = (a[8:7] == 2'h0);
      3'h2: protect_hit = (a[8:7] == 2'h1);
      3'h3: protect_hit = (a[8:7] == 2'h2);
      3'h4: protect_hit = (a[8:7] == 2'h3);
      3'h5: protect_hit = (a[8] == 1'b0);
      3'h6: protect_hit = (a[8:4] == 5'h00);
      3'h7: protect_hit = (a[8:4] == 5'h1F);
      default: protect_hit = 1'b0;
    endcase
  endfunction
endpackage
`default_nettype wire

// [src/spi_flash_sector_protect.sv]
`default_nettype none
module spi_flash_sector_protect #(
  parameter int unsigned write_cycles = nvm_pkg::write_cycles
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic write_guard_n,
  output var logic so_q,
  output var logic so_oe_n_q,
  output var logic standby_q
);
  // -------------------------------------------------------------------------
  // Frame control on the serial clock
  // -------------------------------------------------------------------------
  logic frame_rst;
  logic link_ok_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_n;
  logic [15:0] sr_q;
  logic [7:0] op_q;
  logic [7:0] op_n;
  logic [7:0] op_cur;
  logic [8:0] addr_n;
  logic [8:0] rd_addr_q;
  logic [2:0] ptr_q;
  logic rd_phase;
  logic st_phase;
  logic [7:0] mem_q [nvm_pkg::mem_words];
  logic [7:0] page_q [nvm_pkg::sector_bytes];
  logic [7:0] boff;
  logic [8:0] prog_addr_q;
  nvm_pkg::status_byte_t stat_byte_q;
  nvm_pkg::status_byte_t stat_out;
  nvm_pkg::act_t act_q;
  nvm_pkg::act_t act_d;
  logic busy_l1_q;
  logic busy_l2_q;
  logic [2:0] prot_l1_q;
  logic [2:0] prot_l2_q;
  logic [7:0] rd_byte;
  logic busy_q;
  logic [2:0] prot_q;

  // deselect clears the counter, shift register, opcode, read address and bit pointer and floats the output
  assign frame_rst = rst | cs_n;
  assign cnt_n = cnt_q + 8'h01;
  // new bits enter at the bottom, so the first bit ends up as MSB
  assign op_n = {sr_q[6:0], si};
  // only the low nine address bits are kept
  assign addr_n = {sr_q[7:0], si};
  assign op_cur = (cnt_n == nvm_pkg::op_end) ? op_n : op_q;
  assign rd_phase = (op_q == nvm_pkg::cmd_read) &&
                    (cnt_q >= nvm_pkg::addr_end);
  assign st_phase = (op_q == nvm_pkg::cmd_status_read) &&
                    (cnt_q >= nvm_pkg::op_end);
  assign boff = cnt_n - nvm_pkg::first_byte_end;
  assign rd_byte = mem_q[rd_addr_q];

  // arms on a real high-to-low edge of chip select
  always_ff @(negedge cs_n or posedge rst) begin
    if (rst) begin
      link_ok_q <= 1'b0;
    end else begin
      link_ok_q <= 1'b1;
    end
  end

  // counter starts at the first rise and just waits if sck halts
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_q <= 8'h00;
      sr_q <= 16'h0000;
      op_q <= 8'h00;
      rd_addr_q <= 9'h000;
      ptr_q <= 3'h0;
    end else if (link_ok_q) begin
      if (cnt_q != 8'hFF) begin
        cnt_q <= cnt_n;
      end
      sr_q <= {sr_q[14:0], si};
      if (cnt_n == nvm_pkg::op_end) begin
        op_q <= op_n;
      end
      // load, then step the address after each byte sent
      if (op_q == nvm_pkg::cmd_read && cnt_n == nvm_pkg::addr_end) begin
        rd_addr_q <= addr_n;
      end else if (rd_phase && ptr_q == 3'h7) begin
        rd_addr_q <= rd_addr_q + 9'h001;
      end
      // pointer steps every clock of a read or status phase and wraps after eight bits
      if (rd_phase || st_phase) begin
        ptr_q <= ptr_q + 3'h1;
      end
    end
  end

  // decoded once, so clocking on after an enable changes nothing while the frame stays under 256 clocks
  // only the exact final bit count leaves a write armed
  always_comb begin
    act_d = nvm_pkg::act_none;
    if (cnt_n >= nvm_pkg::op_end) begin
      case (op_cur)
        nvm_pkg::write_latch_set_cmd: act_d = nvm_pkg::act_latch_set;
        nvm_pkg::write_latch_clear_cmd: act_d = nvm_pkg::act_latch_clr;
        nvm_pkg::cmd_program: begin
          // 152 clocks make a sector program
          if (cnt_n == nvm_pkg::prog_end) begin
            act_d = nvm_pkg::act_prog;
          end
        end
        nvm_pkg::cmd_status_write: begin
          // two bytes make a status program
          if (cnt_n == nvm_pkg::stat_end) begin
            act_d = nvm_pkg::act_stat;
          end
        end
        default: act_d = nvm_pkg::act_none;
      endcase
    end
  end

  // Survives deselect so the system side can act on it; assumes no sck
  // edges while chip select is high, as both SPI modes keep sck idle
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      act_q <= nvm_pkg::act_none;
      prog_addr_q <= 9'h000;
      stat_byte_q <= '0;
    end else if (link_ok_q) begin
      act_q <= act_d;
      if (op_q == nvm_pkg::cmd_program && cnt_n == nvm_pkg::addr_end) begin
        prog_addr_q <= addr_n;
      end
      if (op_q == nvm_pkg::cmd_status_write &&
          cnt_n == nvm_pkg::stat_end) begin
        stat_byte_q <= op_n;
      end
    end
  end

  // Page buffer holds data bytes past deselect until the next program frame rewrites them
  always_ff @(posedge sck) begin
    if (link_ok_q && !frame_rst && op_q == nvm_pkg::cmd_program &&
        cnt_n >= nvm_pkg::first_byte_end &&
        cnt_n <= nvm_pkg::prog_end && cnt_n[2:0] == 3'h0) begin
      page_q[boff[6:3]] <= op_n;
    end
  end

  // Busy and protection brought onto the serial clock
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      busy_l1_q <= 1'b0;
      busy_l2_q <= 1'b0;
      prot_l1_q <= nvm_pkg::protect_reset;
      prot_l2_q <= nvm_pkg::protect_reset;
    end else begin
      busy_l1_q <= busy_q;
      busy_l2_q <= busy_l1_q;
      prot_l1_q <= prot_q;
      prot_l2_q <= prot_l1_q;
    end
  end

  // reserved bits are forced to zero
  assign stat_out = '{zero: 5'h00, protect_select: prot_l2_q};

  // output moves on the falling edge only
  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      so_q <= 1'b0;
      so_oe_n_q <= 1'b1;
    end else if (rd_phase) begin
      so_q <= rd_byte[~ptr_q];
      so_oe_n_q <= 1'b0;
    end else if (st_phase) begin
      // ones while writing, live status bit afterwards
      so_q <= busy_l2_q | stat_out[~ptr_q];
      so_oe_n_q <= 1'b0;
    end else begin
      so_q <= 1'b0;
      so_oe_n_q <= 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // System clock side: commit and self-timed write
  // -------------------------------------------------------------------------
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic wg_s1_q;
  logic wg_s2_q;
  nvm_pkg::act_t act_s1_q;
  nvm_pkg::act_t act_s2_q;
  logic cs_rise;
  logic cs_fall;
  logic drop_q;
  logic guard_ok;
  logic latch_q;
  logic kind_q;
  logic [15:0] timer_q;
  logic write_end;
  logic start_prog;
  logic start_stat;

  // Pin synchronisers; action code is already stable at deselect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      wg_s1_q <= 1'b0;
      wg_s2_q <= 1'b0;
      act_s1_q <= nvm_pkg::act_none;
      act_s2_q <= nvm_pkg::act_none;
    end else begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      wg_s1_q <= write_guard_n;
      wg_s2_q <= wg_s1_q;
      act_s1_q <= act_q;
      act_s2_q <= act_s1_q;
    end
  end

  assign cs_rise = cs_s2_q & ~cs_s3_q;
  assign cs_fall = ~cs_s2_q & cs_s3_q;

  // a guard drop inside a frame cancels that frame's write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drop_q <= 1'b0;
    end else if (!cs_s2_q && !wg_s2_q) begin
      drop_q <= 1'b1;
    end else if (cs_fall) begin
      drop_q <= 1'b0;
    end
  end

  assign guard_ok = wg_s2_q & ~drop_q;
  assign write_end = busy_q && (timer_q == 16'h0000);
  // latch and guard gate both writes; protection gates only the sector program
  assign start_prog = cs_rise && act_s2_q == nvm_pkg::act_prog &&
                      latch_q && guard_ok && !busy_q &&
                      !nvm_pkg::protect_hit(prot_q, prog_addr_q);
  assign start_stat = cs_rise && act_s2_q == nvm_pkg::act_stat &&
                      latch_q && guard_ok && !busy_q;

  // set wins over the automatic clear at program end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_q <= 1'b0;
    end else if (cs_rise && act_s2_q == nvm_pkg::act_latch_set) begin
      latch_q <= 1'b1;
    end else if ((cs_rise && act_s2_q == nvm_pkg::act_latch_clr) ||
                 (write_end && kind_q)) begin
      latch_q <= 1'b0;
    end
  end

  // busy for exactly write_cycles clocks; nothing cuts it short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      kind_q <= 1'b0;
      timer_q <= 16'h0000;
    end else if (start_prog || start_stat) begin
      busy_q <= 1'b1;
      kind_q <= start_prog;
      timer_q <= 16'(write_cycles - 1);
    end else if (busy_q) begin
      if (write_end) begin
        busy_q <= 1'b0;
      end else begin
        timer_q <= timer_q - 16'h0001;
      end
    end
  end

  // protection held until the next status program
  // only the three select bits are stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prot_q <= nvm_pkg::protect_reset;
    end else if (start_stat) begin
      prot_q <= stat_byte_q.protect_select;
    end
  end

  // bytes wrap inside the sector rather than spill over
  always_ff @(posedge clk) begin
    if (start_prog) begin
      for (int i = 0; i < nvm_pkg::sector_bytes; i++) begin
        mem_q[{prog_addr_q[8:4], prog_addr_q[3:0] + 4'(i)}] <= page_q[i];
      end
    end
  end

  // standby only when deselected and idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      standby_q <= 1'b1;
    end else begin
      standby_q <= cs_s2_q & ~busy_q;
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  chk_oe_deselect: assert property (@(posedge clk) disable iff (rst)
    cs_s2_q |-> so_oe_n_q) else $error("output driven while deselected");
  chk_write_length: assert property (@(posedge clk) disable iff (rst)
    (start_prog || start_stat) |=>
      busy_q && timer_q == 16'(write_cycles - 1))
    else $error("write timer not loaded");
  chk_write_stop: assert property (@(posedge clk) disable iff (rst)
    write_end |=> !busy_q) else $error("busy outlived timer");
  chk_latch_autoclr: assert property (@(posedge clk) disable iff (rst)
    (write_end && kind_q && !cs_rise) |=> !latch_q)
    else $error("latch kept after program");
  chk_guard_blocks: assert property (@(posedge clk) disable iff (rst)
    !wg_s2_q |=> !$rose(busy_q)) else $error("write with guard low");
  chk_guard_abandon: assert property (@(posedge clk) disable iff (rst)
    (drop_q && cs_rise) |=> !$rose(busy_q))
    else $error("write after guard drop");
  chk_latch_needed: assert property (@(posedge clk) disable iff (rst)
    $rose(busy_q) |-> $past(latch_q)) else $error("write without latch");
  chk_protect_refuse: assert property (@(posedge clk) disable iff (rst)
    ($rose(busy_q) && kind_q) |->
      !nvm_pkg::protect_hit(prot_q, prog_addr_q))
    else $error("protected sector programmed");
  // A program armed in the last frame is still shown at the next first edge
  chk_prog_count: assert property (
    @(posedge sck) disable iff (frame_rst)
    (act_q == nvm_pkg::act_prog && cnt_q != 8'h00) |->
      cnt_q == nvm_pkg::prog_end) else $error("program armed at wrong count");
  chk_read_wrap: assert property (@(posedge sck) disable iff (frame_rst)
    (rd_phase && ptr_q == 3'h7 && rd_addr_q == 9'h1FF) |=>
      rd_addr_q == 9'h000) else $error("read address did not wrap");
  chk_ptr_wrap: assert property (@(posedge sck) disable iff (frame_rst)
    (st_phase && ptr_q == 3'h7) |=> ptr_q == 3'h0)
    else $error("status pointer did not wrap");
  chk_powerup_idle: assert property (@(posedge sck) disable iff (rst)
    !link_ok_q |=> act_q == nvm_pkg::act_none)
    else $error("command taken before select edge");
  chk_busy_awake: assert property (@(posedge clk) disable iff (rst)
    busy_q |=> !standby_q) else $error("standby during write");
  chk_latch_set: assert property (@(posedge clk) disable iff (rst)
    (cs_rise && act_s2_q == nvm_pkg::act_latch_set) |=> latch_q)
    else $error("enable latch not set");
  chk_prot_load: assert property (@(posedge clk) disable iff (rst)
    start_stat |=> prot_q == $past(stat_byte_q.protect_select))
    else $error("protect bits not stored");
  chk_prot_hold: assert property (@(posedge clk) disable iff (rst)
    !start_stat |=> $stable(prot_q)) else $error("protection changed");

  cov_prog: cover property (@(posedge clk) disable iff (rst) start_prog);
  cov_stat: cover property (@(posedge clk) disable iff (rst) start_stat);
  cov_busy_poll: cover property (@(posedge sck) disable iff (frame_rst)
    st_phase && busy_l2_q);
  cov_wrap: cover property (@(posedge sck) disable iff (frame_rst)
    rd_phase && rd_addr_q == 9'h1FF && ptr_q == 3'h7);
endmodule
`default_nettype wire

// [testbench/spi_master_model.sv]
`default_nettype none
module spi_master_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Half of the 80 ns link period
  localparam int half = 40;
  logic [7:0] rx [$];

  // Link idles low and deselected, so the first frame gives a falling select
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // ---------------------------------------------------------------------
  // One framed transfer, mode 0, captures the output pin on rising edges
  // ---------------------------------------------------------------------
  // select held through frame
  task automatic xfer(input logic [7:0] tx[$], input int nbits,
                      input bit stall);
    logic [7:0] sh;
    sh = 8'h00;
    rx.delete();
    #7;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si = (i / 8 < tx.size()) ? tx[i / 8][7 - i % 8] : 1'b0;
      if (stall && i % 8 == 4) #730;
      #half;
      sck = 1'b1;
      sh = {sh[6:0], so_pin};
      if (i % 8 == 7) rx.push_back(sh);
      #half;
      sck = 1'b0;
    end
    #half;
    cs_n = 1'b1;
    // A released line must not keep showing its last bit
    si = ~si;
    // Deselect time before any next frame
    #2000;
  endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // Short write time keeps the run small; checks scale with it
  localparam int wc = 400;
  logic clk, rst, guard, sck, cs_n, si, so_q, so_oe_n_q, standby_q;
  wire so_pin;
  int n_fail, n_tests, seed;
  logic [7:0] exp_mem [512];
  bit known [512];
  logic [7:0] tx [$];
  logic [8:0] tbl [8];
  logic [8:0] a;

  // Undriven output floats, so a byte read while off never matches
  assign so_pin = so_oe_n_q ? 1'bz : so_q;

  spi_flash_sector_protect #(.write_cycles(wc)) u_dut (.clk(clk),
    .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .write_guard_n(guard),
    .so_q(so_q), .so_oe_n_q(so_oe_n_q), .standby_q(standby_q));
  spi_master_model u_master (.sck(sck), .cs_n(cs_n), .si(si),
    .so_pin(so_pin));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Expected protected range, written as plain address bounds
  function automatic bit hit(input logic [2:0] s, input logic [8:0] p);
    case (s)
      3'h1: hit = p < 9'h080;
      3'h2: hit = p >= 9'h080 && p < 9'h100;
      3'h3: hit = p >= 9'h100 && p < 9'h180;
      3'h4: hit = p >= 9'h180;
      3'h5: hit = p < 9'h100;
      3'h6: hit = p < 9'h010;
      3'h7: hit = p >= 9'h1F0;
      default: hit = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------------
  // Command tasks
  // ---------------------------------------------------------------------
  task automatic cmd1(input logic [7:0] op);
    tx.delete();
    tx.push_back(op);
    u_master.xfer(tx, 8, 1'b0);
  endtask

  task automatic hdr(input logic [7:0] op, input logic [8:0] p);
    tx.delete();
    tx.push_back(op);
    tx.push_back({7'h00, p[8]});
    tx.push_back(p[7:0]);
  endtask

  // Busy span after deselect: long for a write, nothing for a refusal
  task automatic wait_write(input bit ok);
    int n;
    n = 0;
    repeat (8) @(negedge clk);
    while (standby_q !== 1'b1 && n < wc + 100) begin
      @(negedge clk);
      n++;
    end
    check({31'h0, n > wc / 2 && n <= wc}, {31'h0, ok});
  endtask

  task automatic prog(input logic [8:0] p, input int nb, input bit ok,
                      input bit stall, input bit lead);
    logic [7:0] d;
    hdr(nvm_pkg::cmd_program, p);
    if (lead) tx.push_front(nvm_pkg::write_latch_set_cmd);
    // exactly 16 bytes, all inside one sector
    for (int k = 0; k < 16; k++) begin
      d = 8'($random(seed));
      tx.push_back(d);
      if (ok) begin
        exp_mem[{p[8:4], 4'(k)}] = d;
        known[{p[8:4], 4'(k)}] = 1'b1;
      end
    end
    u_master.xfer(tx, nb, stall);
  endtask

  task automatic rd(input logic [8:0] p, input int n, input bit stall);
    logic [8:0] q;
    hdr(nvm_pkg::cmd_read, p);
    u_master.xfer(tx, 24 + 8 * n, stall);
    for (int k = 0; k < n; k++) begin
      q = p + 9'(k);
      if (known[q]) check(u_master.rx[3 + k], exp_mem[q]);
    end
  endtask

  task automatic sread(input logic [7:0] e);
    cmd1(nvm_pkg::cmd_status_read);
    tx.delete();
    tx.push_back(nvm_pkg::cmd_status_read);
    u_master.xfer(tx, 24, 1'b0);
    check(u_master.rx[1], e);
    check(u_master.rx[2], e);
  endtask

  task automatic swrite(input logic [2:0] s, input bit ok);
    cmd1(nvm_pkg::write_latch_set_cmd);
    tx.delete();
    tx.push_back(nvm_pkg::cmd_status_write);
    tx.push_back({5'h00, s});
    u_master.xfer(tx, 16, 1'b0);
    wait_write(ok);
  endtask

  // Watchdog sized well above the expected run of about 1.5 ms
  initial begin
    #6000000;
    n_fail++;
    end_sim;
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    seed = 32'h2B68;
    rst = 1'b1;
    guard = 1'b1;
    n_fail = 0;
    n_tests = 0;
    tbl = '{9'h000, 9'h000, 9'h080, 9'h100, 9'h180, 9'h0F0, 9'h000,
            9'h1F0};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    check(so_oe_n_q, 1'b1);
    check(standby_q, 1'b1);
    sread(8'h00);
    prog(9'h030, 152, 0, 0, 0);
    wait_write(0);
    cmd1(nvm_pkg::write_latch_set_cmd);
    prog(9'h030, 152, 1, 0, 0);
    sread(8'hFF);
    wait_write(1);
    rd(9'h030, 16, 0);
    prog(9'h030, 152, 0, 0, 0);
    wait_write(0);
    cmd1(nvm_pkg::write_latch_set_cmd);
    prog(9'h1F0, 152, 1, 0, 0);
    // guard drop after launch leaves the write running
    @(negedge clk) guard = 1'b0;
    wait_write(1);
    @(negedge clk) guard = 1'b1;
    cmd1(nvm_pkg::write_latch_set_cmd);
    prog(9'h000, 152, 1, 0, 0);
    wait_write(1);
    rd(9'h1FE, 4, 0);
    cmd1(nvm_pkg::write_latch_set_cmd);
    prog(9'h100, 152, 1, 1, 0);
    wait_write(1);
    rd(9'h100, 16, 1);
    prog(9'h030, 160, 0, 0, 1);
    wait_write(0);
    cmd1(nvm_pkg::write_latch_clear_cmd);
    prog(9'h030, 152, 0, 0, 0);
    wait_write(0);
    // deselect one bit early or late
    for (int nb = 151; nb <= 153; nb += 2) begin
      cmd1(nvm_pkg::write_latch_set_cmd);
      prog(9'h030, nb, 0, 0, 0);
      wait_write(0);
    end
    @(negedge clk) guard = 1'b0;
    cmd1(nvm_pkg::write_latch_set_cmd);
    prog(9'h030, 152, 0, 0, 0);
    wait_write(0);
    swrite(3'h3, 0);
    rd(9'h030, 16, 0);
    sread(8'h00);
    @(negedge clk) guard = 1'b1;
    cmd1(nvm_pkg::write_latch_set_cmd);
    fork
      prog(9'h030, 152, 0, 0, 0);
      begin
        #4000;
        @(negedge clk) guard = 1'b0;
        // Back high before deselect, so only the drop itself cancels
        #2000;
        @(negedge clk) guard = 1'b1;
      end
    join
    @(negedge clk) guard = 1'b1;
    wait_write(0);
    rd(9'h030, 16, 0);
    // reset inside a stalled frame; later bits form an enable
    tx = {8'h06, 8'h00, 8'h60};
    fork
      u_master.xfer(tx, 24, 1'b1);
      begin
        #1800;
        @(negedge clk) rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
      end
    join
    prog(9'h030, 152, 0, 0, 0);
    wait_write(0);
    rd(9'h030, 16, 0);
    // every nonzero protect code, random and protected sectors
    for (int s = 1; s < 8; s++) begin
      swrite(3'(s), 1);
      sread({5'h00, 3'(s)});
      for (int j = 0; j < 2; j++) begin
        a = j ? tbl[s] : 9'($random(seed)) & 9'h1F0;
        cmd1(nvm_pkg::write_latch_set_cmd);
        prog(a, 152, !hit(3'(s), a), 0, 0);
        wait_write(!hit(3'(s), a));
        rd(a, 16, 0);
      end
    end
    swrite(3'h0, 1);
    sread(8'h00);
    end_sim;
  end
endmodule
`default_nettype wire
